// *** csw_pkg.sv ***
// Constants, field positions and carrier types for the upper main status word.
// Assumes one device clock; no bus of its own, the host port is a plain read/command strobe.
//
// Contract
// - Bit 3 is the OR of all 64 per-node cyclic error flags, raises the interrupt, and falls only when all are zero.
// - Bit 4 sets on a data communication error and raises the interrupt.
// - Bit 5 sets when a remote node reports a reception processing error and raises the interrupt.
// - Bit 6 sets on an illegal host access such as send with an empty transmit FIFO and raises the interrupt.
// - Environment register 0 bit 9 selects how bits 4, 5 and 6 are cleared.
// - With that bit one the group clear command clears the flags whose bits are set; with it zero the command is ignored.
// - Bit 8 sets on any host write of output port data and clears only after two complete error-free cyclic rounds.
// - Bit 9 sets on a transmit FIFO write and clears on the send command or the transmit FIFO reset command.
// - Bit 10 sets when remote data lands in the receive FIFO and clears once the host has read every word.
// - Bit 12 sets when cyclic communication begins.
// - Bit 13 reads one while the device is in reset.
// - Bit 14 reads one during any system or data communication transaction.
// - Bit 15 is one only while environment bit 8 is one and a host break command is in progress.
// - The failing node number records only the most recent data communication or remote reception error.
`default_nettype none
package csw_pkg;
  localparam int NODES = 64;
  localparam int NODE_W = 6;
  localparam int BIT_CYC_ERR = 3;
  localparam int BIT_DATA_ERR = 4;
  localparam int BIT_RX_ERR = 5;
  localparam int BIT_ACC_ERR = 6;
  localparam int BIT_OUT_PEND = 8;
  localparam int BIT_TX_NE = 9;
  localparam int BIT_RX_NE = 10;
  localparam int BIT_CYC_ACT = 12;
  localparam int BIT_RST_ACT = 13;
  localparam int BIT_XFER_ACT = 14;
  localparam int BIT_BRK_ACT = 15;
  localparam int ENV_BRK_EN = 8;
  localparam int ENV_CLR_EN = 9;
  localparam logic [15:0] CMD_GRP_CLR = 16'h0400;
  localparam logic [15:0] CMD_GRP_MASK = 16'hFF00;
  localparam logic [15:0] CMD_SEND = 16'h1000;
  localparam logic [15:0] CMD_TX_RESET = 16'h0200;
  localparam logic [15:0] CMD_BREAK = 16'h0610;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] STATUS_IN_RESET = 16'h2000;
  localparam logic [1:0] ROUNDS_TO_CLEAR = 2'h2;

  // Event strobes from the engines and FIFOs
  typedef struct packed {
    logic data_err;
    logic rx_err;
    logic out_write;
    logic round_ok;
    logic round_err;
    logic tx_write;
    logic rx_land;
    logic rx_drained;
    logic cyc_start;
    logic xfer_busy;
    logic brk_done;
    logic [NODE_W-1:0] err_node;
  } csw_evt_t;

  typedef enum logic [1:0] {
    BRK_IDLE = 2'b00,
    BRK_RUN = 2'b01
  } csw_brk_t;
endpackage : csw_pkg
`default_nettype wire

// *** csw_status.sv ***
// Upper main status word (bits 3..15) with interrupt output.
// Assumes engines and FIFOs give one-cycle strobes on core_clk; command is a decoded one-cycle strobe.
`timescale 1ns/1ps
`default_nettype none
module csw_status (
  input wire logic core_clk, // 50 MHz clock
  input wire logic rst, // Sync reset, high
  input wire logic ce, // Clock enable
  input wire logic [csw_pkg::NODES-1:0] cyc_err_flags, // Per-node cyclic errors
  input wire csw_pkg::csw_evt_t evt, // Engine events
  input wire logic [15:0] env_cfg_zero, // Environment register 0
  input wire logic cmd_valid, // Command strobe
  input wire logic [15:0] cmd_word, // Command word
  input wire logic tx_fifo_empty, // Transmit FIFO empty
  output logic [15:0] main_status_word, // Status read data
  output logic [csw_pkg::NODE_W-1:0] fail_node, // Last failing node
  output logic irq // Interrupt, high
);
  import csw_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode
  function automatic logic is_cmd(input logic [15:0] w, input logic [15:0] c);
    return w == c;
  endfunction

  logic grp_cmd;
  logic send_cmd;
  logic txrst_cmd;
  logic brk_cmd;
  logic clr_en;
  assign grp_cmd = cmd_valid && ((cmd_word & CMD_GRP_MASK) == CMD_GRP_CLR);
  assign send_cmd = cmd_valid && is_cmd(cmd_word, CMD_SEND);
  assign txrst_cmd = cmd_valid && is_cmd(cmd_word, CMD_TX_RESET);
  assign brk_cmd = cmd_valid && is_cmd(cmd_word, CMD_BREAK);
  assign clr_en = env_cfg_zero[ENV_CLR_EN];

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky error flags, set wins over clear
  logic data_comm_error_flag_ff;
  logic remote_rx_error_flag_ff;
  logic host_access_error_flag_ff;
  logic acc_evt;
  logic [2:0] grp_clr;
  assign acc_evt = send_cmd && tx_fifo_empty;
  assign grp_clr = (grp_cmd && clr_en) ? cmd_word[6:4] : 3'h0;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_comm_error_flag_ff <= 1'b0;
      remote_rx_error_flag_ff <= 1'b0;
      host_access_error_flag_ff <= 1'b0;
    end else if (ce) begin
      data_comm_error_flag_ff <= evt.data_err | (data_comm_error_flag_ff & ~grp_clr[0]);
      remote_rx_error_flag_ff <= evt.rx_err | (remote_rx_error_flag_ff & ~grp_clr[1]);
      host_access_error_flag_ff <= acc_evt | (host_access_error_flag_ff & ~grp_clr[2]);
    end
  end

  // Failing node, latest error overwrites
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fail_node <= '0;
    end else if (ce && (evt.data_err || evt.rx_err)) begin
      fail_node <= evt.err_node;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pending output data: two clean rounds after the last write
  logic out_pend_ff;
  logic [1:0] rounds_ff;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      out_pend_ff <= 1'b0;
      rounds_ff <= 2'h0;
    end else if (ce) begin
      if (evt.out_write) begin
        out_pend_ff <= 1'b1;
        rounds_ff <= 2'h0;
      end else if (out_pend_ff) begin
        if (evt.round_err) begin
          rounds_ff <= 2'h0;
        end else if (evt.round_ok) begin
          if (rounds_ff + 2'h1 == ROUNDS_TO_CLEAR) begin
            out_pend_ff <= 1'b0;
            rounds_ff <= 2'h0;
          end else begin
            rounds_ff <= rounds_ff + 2'h1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // FIFO occupancy and cyclic start flags
  logic tx_ne_ff;
  logic rx_ne_ff;
  logic cyc_act_ff;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_ne_ff <= 1'b0;
      rx_ne_ff <= 1'b0;
      cyc_act_ff <= 1'b0;
    end else if (ce) begin
      tx_ne_ff <= evt.tx_write | (tx_ne_ff & ~(send_cmd | txrst_cmd));
      rx_ne_ff <= evt.rx_land | (rx_ne_ff & ~evt.rx_drained);
      cyc_act_ff <= evt.cyc_start | cyc_act_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Break tracking
  csw_brk_t brk_ff;
  csw_brk_t nxt_brk;
  always_comb begin
    nxt_brk = brk_ff;
    case (brk_ff)
      BRK_IDLE: begin
        if (brk_cmd && env_cfg_zero[ENV_BRK_EN]) begin
          nxt_brk = BRK_RUN;
        end
      end
      BRK_RUN: begin
        if (evt.brk_done || !env_cfg_zero[ENV_BRK_EN]) begin
          nxt_brk = BRK_IDLE;
        end
      end
      default: nxt_brk = BRK_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      brk_ff <= BRK_IDLE;
    end else if (ce) begin
      brk_ff <= nxt_brk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status word and interrupt
  logic cyclic_error_summary;
  logic [15:0] nxt_status;
  assign cyclic_error_summary = |cyc_err_flags;

  always_comb begin
    nxt_status = STATUS_RESET;
    nxt_status[BIT_CYC_ERR] = cyclic_error_summary;
    nxt_status[BIT_DATA_ERR] = data_comm_error_flag_ff;
    nxt_status[BIT_RX_ERR] = remote_rx_error_flag_ff;
    nxt_status[BIT_ACC_ERR] = host_access_error_flag_ff;
    nxt_status[BIT_OUT_PEND] = out_pend_ff;
    nxt_status[BIT_TX_NE] = tx_ne_ff;
    nxt_status[BIT_RX_NE] = rx_ne_ff;
    nxt_status[BIT_CYC_ACT] = cyc_act_ff;
    nxt_status[BIT_XFER_ACT] = evt.xfer_busy;
    nxt_status[BIT_BRK_ACT] = (brk_ff == BRK_RUN) && env_cfg_zero[ENV_BRK_EN];
  end

  // Registered read data; reset shows only the reset-busy bit
  always_ff @(posedge core_clk) begin
    if (rst) begin
      main_status_word <= STATUS_IN_RESET;
      irq <= 1'b0;
    end else if (ce) begin
      main_status_word <= nxt_status;
      irq <= |nxt_status[BIT_ACC_ERR:BIT_CYC_ERR];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence out_wr_s;
    evt.out_write && ce;
  endsequence
  sequence grp_clr_s;
    ce && grp_cmd && clr_en;
  endsequence
  sequence brk_go_s;
    ce && brk_cmd && env_cfg_zero[ENV_BRK_EN] && brk_ff == BRK_IDLE;
  endsequence
  sequence round_ok_s;
    ce && evt.round_ok && !evt.round_err && !evt.out_write;
  endsequence

  reset_busy_a: assert property (@(posedge core_clk) rst |=> main_status_word[BIT_RST_ACT])
    else $error("reset busy bit not shown");
  irq_follow_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && (cyclic_error_summary || data_comm_error_flag_ff) |=> irq)
    else $error("interrupt missing with error set");
  cyc_or_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && !$past(rst) && !(|cyc_err_flags) |=> !main_status_word[BIT_CYC_ERR])
    else $error("cyclic summary stuck");
  grp_ignore_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && grp_cmd && !clr_en && data_comm_error_flag_ff |=> data_comm_error_flag_ff)
    else $error("group clear not ignored");
  grp_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && grp_cmd && clr_en && cmd_word[5] && !evt.rx_err |=> !remote_rx_error_flag_ff)
    else $error("group clear failed");
  acc_err_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && send_cmd && tx_fifo_empty |=> host_access_error_flag_ff)
    else $error("access error not flagged");
  out_pend_a: assert property (@(posedge core_clk) disable iff (rst)
    out_wr_s |=> out_pend_ff ##1 out_pend_ff)
    else $error("output pending cleared early");
  tx_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && txrst_cmd && !evt.tx_write |=> !tx_ne_ff)
    else $error("tx flag not cleared");
  rx_set_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && evt.rx_land |=> rx_ne_ff)
    else $error("rx flag not set");
  brk_zero_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && !env_cfg_zero[ENV_BRK_EN] |=> !main_status_word[BIT_BRK_ACT])
    else $error("break bit without enable");
  node_last_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && evt.data_err |=> fail_node == $past(evt.err_node))
    else $error("fail node not latest");
  undef_zero_a: assert property (@(posedge core_clk) disable iff (rst)
    !main_status_word[7] && !main_status_word[11] && main_status_word[2:0] == 3'h0)
    else $error("undefined bits nonzero");

  // Error flags set on their events and fall only through an accepted group clear
  data_set_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && evt.data_err |=> data_comm_error_flag_ff)
    else $error("data error flag not set");
  rx_err_set_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && evt.rx_err |=> remote_rx_error_flag_ff)
    else $error("remote rx error flag not set");
  data_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && !grp_cmd && data_comm_error_flag_ff |=> data_comm_error_flag_ff)
    else $error("data error flag fell alone");
  data_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    grp_clr_s ##0 (cmd_word[4] && !evt.data_err) |=> !data_comm_error_flag_ff)
    else $error("data error flag not cleared");
  acc_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    grp_clr_s ##0 (cmd_word[6] && !acc_evt) |=> !host_access_error_flag_ff)
    else $error("access error flag not cleared");
  rx_keep_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && grp_cmd && !clr_en && remote_rx_error_flag_ff |=> remote_rx_error_flag_ff)
    else $error("rx error cleared while disabled");
  acc_keep_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && grp_cmd && !clr_en && host_access_error_flag_ff |=> host_access_error_flag_ff)
    else $error("access error cleared while disabled");
  acc_none_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && send_cmd && !tx_fifo_empty && !host_access_error_flag_ff |=> !host_access_error_flag_ff)
    else $error("access error on legal send");
  rx_node_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && evt.rx_err |=> fail_node == $past(evt.err_node))
    else $error("fail node not latest rx error");

  // Interrupt follows the shown error bits
  irq_match_a: assert property (@(posedge core_clk) disable iff (rst)
    irq == (|main_status_word[BIT_ACC_ERR:BIT_CYC_ERR]))
    else $error("interrupt differs from error bits");
  cyc_set_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && (|cyc_err_flags) |=> main_status_word[BIT_CYC_ERR])
    else $error("cyclic summary not set");

  // Output pending round count
  pend_show_a: assert property (@(posedge core_clk) disable iff (rst)
    out_wr_s ##1 ce |=> main_status_word[BIT_OUT_PEND])
    else $error("output pending not shown");
  pend_stay_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && out_pend_ff && !evt.round_ok |=> out_pend_ff)
    else $error("output pending fell without round");
  pend_err_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && out_pend_ff && evt.round_err && !evt.out_write |=> out_pend_ff && rounds_ff == 2'h0)
    else $error("failed round did not restart count");
  pend_one_a: assert property (@(posedge core_clk) disable iff (rst)
    round_ok_s ##0 (out_pend_ff && rounds_ff == 2'h0) |=> out_pend_ff)
    else $error("output pending cleared after one round");
  pend_two_a: assert property (@(posedge core_clk) disable iff (rst)
    round_ok_s ##0 (out_pend_ff && rounds_ff == 2'h1) |=> !out_pend_ff)
    else $error("output pending kept after two rounds");

  // FIFO occupancy flags
  tx_set_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && evt.tx_write |=> tx_ne_ff)
    else $error("tx flag not set");
  tx_send_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && send_cmd && !evt.tx_write |=> !tx_ne_ff)
    else $error("tx flag kept after send");
  tx_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && tx_ne_ff && !send_cmd && !txrst_cmd |=> tx_ne_ff)
    else $error("tx flag fell alone");
  rx_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && evt.rx_drained && !evt.rx_land |=> !rx_ne_ff)
    else $error("rx flag kept after drain");

  // Busy bits
  cyc_start_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && (evt.cyc_start || cyc_act_ff) |=> cyc_act_ff)
    else $error("cyclic start bit lost");
  xfer_busy_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && evt.xfer_busy |=> main_status_word[BIT_XFER_ACT])
    else $error("transfer busy not shown");
  xfer_idle_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && !evt.xfer_busy |=> !main_status_word[BIT_XFER_ACT])
    else $error("transfer busy without transfer");
  brk_start_a: assert property (@(posedge core_clk) disable iff (rst)
    brk_go_s |=> brk_ff == BRK_RUN)
    else $error("break did not start");
  brk_show_a: assert property (@(posedge core_clk) disable iff (rst)
    brk_go_s ##1 (ce && env_cfg_zero[ENV_BRK_EN]) |=> main_status_word[BIT_BRK_ACT])
    else $error("break busy not shown");
  brk_refuse_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && brk_ff == BRK_IDLE && !(brk_cmd && env_cfg_zero[ENV_BRK_EN]) |=> brk_ff == BRK_IDLE)
    else $error("break started without command");
  brk_end_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && brk_ff == BRK_RUN && evt.brk_done |=> brk_ff == BRK_IDLE)
    else $error("break did not end");

  // Reset word and clock enable freeze
  reset_word_a: assert property (@(posedge core_clk)
    rst |=> main_status_word == STATUS_IN_RESET && !irq)
    else $error("reset word wrong");
  ce_freeze_a: assert property (@(posedge core_clk) disable iff (rst)
    !ce |=> $stable(main_status_word) && $stable(irq))
    else $error("outputs moved with clock enable low");
endmodule // csw_status
`default_nettype wire

// *** csw_host_model.sv ***
// Host CPU model that issues decoded commands to the status word block.
// Assumes csw_pkg is compiled first and commands are one-cycle strobes on core_clk.
`timescale 1ns/1ps
`default_nettype none
module csw_host_model (
  input wire logic core_clk, // Device clock
  output logic cmd_valid, // Command strobe
  output logic [15:0] cmd_word // Command word
);
  import csw_pkg::*;
  // Idle bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_word = 16'h0000;
  end
  // One-cycle command, then the word is scrambled so nothing can lean on a stale value
  task automatic send_cmd(input logic [15:0] w);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_word <= w;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    cmd_word <= ~w;
    @(posedge core_clk);
    #1;
  endtask
  // Group clear with the chosen flag bits 6..4 set
  task automatic grp_clear(input logic [2:0] m);
    send_cmd(CMD_GRP_CLR | {9'h000, m, 4'h0});
  endtask
endmodule // csw_host_model
`default_nettype wire

// *** center_status_word_upper_bench.sv ***
// Self-checking bench for the upper main status word.
// Assumes csw_pkg, csw_status and csw_host_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module center_status_word_upper_bench;
  import csw_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [NODES-1:0] cyc_err_flags = '0;
  csw_evt_t evt = '0;
  csw_evt_t e;
  logic [15:0] env_cfg_zero = 16'h0000;
  logic tx_fifo_empty = 1'b1;
  logic cmd_valid;
  logic [15:0] cmd_word;
  logic [15:0] main_status_word;
  logic [NODE_W-1:0] fail_node;
  logic irq;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////
  // Clock and instances
  always #10 core_clk = ~core_clk;
  csw_status dut_u (.core_clk(core_clk), .rst(rst), .ce(ce), .cyc_err_flags(cyc_err_flags), .evt(evt),
    .env_cfg_zero(env_cfg_zero), .cmd_valid(cmd_valid), .cmd_word(cmd_word), .tx_fifo_empty(tx_fifo_empty),
    .main_status_word(main_status_word), .fail_node(fail_node), .irq(irq));
  csw_host_model host_u (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_word(cmd_word));
  ////////////////////////////////////////////////////////////
  // Compare, report and close
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bit_is(input int b, input logic v);
    chk($sformatf("status bit %0d", b), {15'h0000, main_status_word[b]}, {15'h0000, v});
  endtask
  task automatic irq_is(input logic v);
    chk("irq", {15'h0000, irq}, {15'h0000, v});
  endtask
  task automatic summarize;
    $display("Checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // One-cycle event pulse, then wait until the status register shows it
  task automatic fire(input csw_evt_t ev);
    @(posedge core_clk);
    evt <= ev;
    @(posedge core_clk);
    evt <= '0;
    @(posedge core_clk);
    #1;
  endtask
  task automatic settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (7) @(posedge core_clk);
    #1;
    chk("reset status", main_status_word, 16'h2000);
    irq_is(1'b0);
    @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    bit_is(BIT_RST_ACT, 1'b0);
    // Cyclic error summary holds until the last node flag drops
    @(posedge core_clk);
    cyc_err_flags[0] <= 1'b1;
    cyc_err_flags[NODES-1] <= 1'b1;
    settle();
    bit_is(BIT_CYC_ERR, 1'b1);
    irq_is(1'b1);
    @(posedge core_clk);
    cyc_err_flags[0] <= 1'b0;
    settle();
    bit_is(BIT_CYC_ERR, 1'b1);
    @(posedge core_clk);
    cyc_err_flags[NODES-1] <= 1'b0;
    settle();
    bit_is(BIT_CYC_ERR, 1'b0);
    irq_is(1'b0);
    // Sticky error flags, last failing node, clear refused then accepted
    e = '0;
    e.data_err = 1'b1;
    e.err_node = 6'h05;
    fire(e);
    bit_is(BIT_DATA_ERR, 1'b1);
    irq_is(1'b1);
    e = '0;
    e.rx_err = 1'b1;
    e.err_node = 6'h29;
    fire(e);
    bit_is(BIT_RX_ERR, 1'b1);
    chk("fail node", {10'h000, fail_node}, 16'h0029);
    host_u.send_cmd(CMD_SEND);
    bit_is(BIT_ACC_ERR, 1'b1);
    host_u.grp_clear(3'h7);
    chk("errors kept", main_status_word & 16'h0070, 16'h0070);
    @(posedge core_clk);
    env_cfg_zero <= 16'h0200;
    for (int i = 4; i <= 6; i++) begin
      host_u.grp_clear(3'(1 << (i - 4)));
      bit_is(i, 1'b0);
      irq_is(i < 6);
    end
    // Output pending needs two clean rounds after the last error
    e = '0;
    e.out_write = 1'b1;
    fire(e);
    bit_is(BIT_OUT_PEND, 1'b1);
    e = '0;
    e.round_ok = 1'b1;
    fire(e);
    e = '0;
    e.round_err = 1'b1;
    fire(e);
    e = '0;
    e.round_ok = 1'b1;
    fire(e);
    bit_is(BIT_OUT_PEND, 1'b1);
    fire(e);
    bit_is(BIT_OUT_PEND, 1'b0);
    // Transmit data flag cleared by send and by FIFO reset
    @(posedge core_clk);
    tx_fifo_empty <= 1'b0;
    e = '0;
    e.tx_write = 1'b1;
    fire(e);
    bit_is(BIT_TX_NE, 1'b1);
    host_u.send_cmd(CMD_SEND);
    bit_is(BIT_TX_NE, 1'b0);
    bit_is(BIT_ACC_ERR, 1'b0);
    fire(e);
    bit_is(BIT_TX_NE, 1'b1);
    host_u.send_cmd(CMD_TX_RESET);
    bit_is(BIT_TX_NE, 1'b0);
    // A write while the clock enable is low is dropped
    @(posedge core_clk);
    ce <= 1'b0;
    fire(e);
    bit_is(BIT_TX_NE, 1'b0);
    @(posedge core_clk);
    ce <= 1'b1;
    // Receive flag, cyclic start and transfer busy
    e = '0;
    e.rx_land = 1'b1;
    fire(e);
    bit_is(BIT_RX_NE, 1'b1);
    e = '0;
    e.rx_drained = 1'b1;
    fire(e);
    bit_is(BIT_RX_NE, 1'b0);
    e = '0;
    e.cyc_start = 1'b1;
    fire(e);
    bit_is(BIT_CYC_ACT, 1'b1);
    @(posedge core_clk);
    evt.xfer_busy <= 1'b1;
    settle();
    bit_is(BIT_XFER_ACT, 1'b1);
    @(posedge core_clk);
    evt.xfer_busy <= 1'b0;
    settle();
    bit_is(BIT_XFER_ACT, 1'b0);
    // Break refused while disabled, then runs until done
    host_u.send_cmd(CMD_BREAK);
    bit_is(BIT_BRK_ACT, 1'b0);
    @(posedge core_clk);
    env_cfg_zero <= 16'h0300;
    host_u.send_cmd(CMD_BREAK);
    bit_is(BIT_BRK_ACT, 1'b1);
    e = '0;
    e.brk_done = 1'b1;
    fire(e);
    bit_is(BIT_BRK_ACT, 1'b0);
    // Dropping the break enable ends a running break
    host_u.send_cmd(CMD_BREAK);
    bit_is(BIT_BRK_ACT, 1'b1);
    @(posedge core_clk);
    env_cfg_zero <= 16'h0200;
    settle();
    bit_is(BIT_BRK_ACT, 1'b0);
    @(posedge core_clk);
    env_cfg_zero <= 16'h0300;
    settle();
    bit_is(BIT_BRK_ACT, 1'b0);
    bit_is(BIT_CYC_ACT, 1'b1);
    chk("undefined bits", main_status_word & 16'h0880, 16'h0000);
    // Mid-run reset shows only the reset-busy bit and drops the sticky start bit
    @(posedge core_clk);
    rst <= 1'b1;
    settle();
    chk("reset status", main_status_word, 16'h2000);
    irq_is(1'b0);
    @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("status after reset", main_status_word, 16'h0000);
    summarize();
  end
endmodule // center_status_word_upper_bench
`default_nettype wire
